// ---- dv/pic_core_model.sv ----
// Behavioural processor core that claims and completes interrupts
`timescale 1ns/10ps
`default_nettype none
module pic_core_model
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic srst,
	// Notification and claim answer
	input wire logic active,
	input wire logic eip,
	input wire logic claim_valid,
	input wire pic_pkg::pic_id_t claim_id,
	// Requests
	output logic claim_rd,
	output logic compl_we,
	output pic_pkg::pic_id_t compl_id,
	output logic [7:0] served_cnt
);
	import pic_pkg::*;
	logic [1:0] st;
	logic [3:0] dly;
	logic slow;
	// Settings are never touched while serving
	always_ff @(posedge core_clk)
	begin
		claim_rd <= 1'b0;
		compl_we <= 1'b0;
		if (srst || !active)
		begin
			st <= 2'h0;
			dly <= 4'h0;
			slow <= 1'b0;
			served_cnt <= 8'h0;
			compl_id <= '0;
		end
		else if (dly != 4'h0)
			dly <= dly - 4'h1;
		else if (st == 2'h0 && eip)
		begin
			claim_rd <= 1'b1;
			st <= 2'h1;
		end
		else if (st == 2'h1)
			st <= 2'h2;
		else if (st == 2'h2 && claim_valid)
		begin
			compl_id <= claim_id;
			st <= (claim_id == '0) ? 2'h0 : 2'h3;
			// Alternate prompt and slow handlers
			dly <= slow ? 4'h7 : 4'h1;
			slow <= ~slow;
		end
		else if (st == 2'h3)
		begin
			compl_we <= 1'b1;
			served_cnt <= served_cnt + 8'h1;
			st <= 2'h0;
			dly <= 4'h2;
		end
	end
endmodule // pic_core_model
`default_nettype wire

// ---- dv/pic_top_tb.sv ----
// Testbench of the platform interrupt controller
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin error_cnt++; $display("[FAIL] %0t got %h want %h", $time, a, b); end end
module pic_top_tb;
	import pic_pkg::*;
	localparam int EN = 0, PRI = 1, THR = 2, PEND = 3, CSR = 4, FEN = 5;
	logic core_clk = 0, srst = 1, enable_we = 0, pri_we = 0, thres_we = 0, fen_we = 0, fen_wdata = 0, pend_we = 0;
	logic tb_claim = 0, tb_compl = 0, csr_we = 0, auto_svc = 0, m_claim, m_compl, eip, claim_valid;
	logic feature_vectored_enable, vector_mode_select, vectored_active, claim_rd, compl_we;
	pic_vec_t src_level = '0, enable_wdata = '0, pend_wdata = '0, source_pending_bits, source_enable_bits;
	pic_id_t pri_sel = '0, tb_cid = '0, m_cid, compl_id, claim_id;
	pic_pri_t pri_wdata = '0, thres_wdata = '0, target_priority_threshold;
	logic [11:0] csr_addr = '0;
	logic [31:0] csr_wdata = '0, csr_rdata;
	logic [7:0] served_cnt;
	int error_cnt = 0, tests_run = 0, cyc = 0;
	assign claim_rd = auto_svc ? m_claim : tb_claim;
	assign compl_we = auto_svc ? m_compl : tb_compl;
	assign compl_id = auto_svc ? m_cid : tb_cid;
	always #20 core_clk = ~core_clk;
	pic_top pic_top_i (.core_clk, .srst, .src_level, .enable_we, .enable_wdata, .pri_we, .pri_sel, .pri_wdata,
		.thres_we, .thres_wdata, .fen_we, .fen_wdata, .pend_we, .pend_wdata, .claim_rd, .compl_we, .compl_id,
		.csr_we, .csr_addr, .csr_wdata, .eip, .claim_id, .claim_valid, .source_pending_bits, .source_enable_bits,
		.target_priority_threshold, .feature_vectored_enable, .vector_mode_select, .vectored_active, .csr_rdata);
	pic_core_model pic_core_model_i (.core_clk, .srst, .active(auto_svc), .eip, .claim_valid, .claim_id,
		.claim_rd(m_claim), .compl_we(m_compl), .compl_id(m_cid), .served_cnt);
	////////////////////////////////////////////////////////////////
	task automatic tick(input int n);
		repeat (n) @(negedge core_clk);
	endtask
	// One strobe per call; d packs id and value where the port needs both
	task automatic wr(input int k, input logic [45:0] d);
		enable_wdata = d;
		pend_wdata = d;
		pri_sel = d[7:2];
		pri_wdata = d[1:0];
		thres_wdata = d[1:0];
		csr_addr = d[13:2];
		csr_wdata = {30'h0, d[1:0]};
		fen_wdata = d[0];
		{enable_we, pri_we, thres_we, pend_we, csr_we, fen_we} = 6'h20 >> k;
		tick(1);
		{enable_we, pri_we, thres_we, pend_we, csr_we, fen_we} = 6'h0;
		tick(1);
	endtask
	task automatic claim(input pic_id_t id);
		tb_claim = 1;
		tick(1);
		tb_claim = 0;
		`CHK({claim_valid, claim_id, eip}, {1'b1, id, 1'b0})
		tick(1);
	endtask
	task automatic compl(input pic_id_t id);
		tb_compl = 1;
		tb_cid = id;
		tick(1);
		tb_compl = 0;
		tick(1);
	endtask
	task automatic give_verdict();
		$display("checks %0d, mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// Ceiling well above the few hundred cycles the tests need
	always @(posedge core_clk)
	begin
		cyc++;
		if (cyc == 2000)
		begin
			error_cnt++;
			give_verdict();
		end
	end
	////////////////////////////////////////////////////////////////
	initial
	begin
		tick(4);
		srst = 0;
		`CHK({eip, source_pending_bits, target_priority_threshold, vector_mode_select}, 50'h0)
		wr(EN, '1);
		wr(PRI, {6'd5, 2'h3});
		wr(PRI, {6'd9, 2'h3});
		wr(PRI, {6'd2, 2'h2});
		wr(THR, 46'h1);
		`CHK({source_enable_bits, target_priority_threshold}, {46'h3fff_ffff_ffff, 2'h1})
		src_level = 46'h112;
		tick(4);
		`CHK({source_pending_bits, eip}, {46'h112, 1'b1})
		claim(5);
		tick(2);
		`CHK(eip, 1'b1)
		claim(9);
		claim(2);
		claim(0);
		tick(4);
		`CHK(source_pending_bits, 46'h0)
		compl(5);
		tick(4);
		`CHK(source_pending_bits, 46'h10)
		src_level = '0;
		claim(5);
		compl(5);
		compl(9);
		compl(2);
		$display("test gateway done");
		wr(PEND, 46'h20_0000);
		wr(PEND, 46'h4);
		tick(2);
		`CHK({source_pending_bits, eip}, {46'h20_0004, 1'b0})
		wr(THR, 46'h0);
		tick(2);
		`CHK(eip, 1'b1)
		wr(EN, ~46'h4);
		claim(22);
		wr(EN, '1);
		claim(3);
		$display("test threshold done");
		wr(CSR, {12'h7d4, 2'h2});
		`CHK(vector_mode_select, 1'b0)
		wr(CSR, {12'h7d0, 2'h2});
		wr(FEN, 46'h1);
		csr_addr = 12'h7d0;
		tick(1);
		`CHK({feature_vectored_enable, vector_mode_select, csr_rdata, vectored_active}, {2'h3, 32'h2, 1'b1})
		wr(CSR, {12'h7d0, 2'h0});
		tick(1);
		`CHK({vector_mode_select, vectored_active}, 2'h0)
		$display("test control done");
		auto_svc = 1;
		src_level = 46'h80_0000_0081;
		tick(4);
		src_level = '0;
		tick(120);
		`CHK({served_cnt, source_pending_bits, eip}, {8'd3, 46'h0, 1'b0})
		$display("test service done");
		give_verdict();
	end
endmodule // pic_top_tb
`default_nettype wire

// ---- verilog/pic_defs.svh ----
// Constants of the platform interrupt controller
// Function
// - Forty-six level sources numbered from one, each with gateway and pending bit.
// - Each source has a programmable priority of 1, 2 or 3.
// - A gateway turns an asserted source level into one request.
// - The core latches each gateway request into the source pending bit.
// - Per-source enable and priority plus a target threshold are writable.
// - Notification is high only if an enabled pending source beats the threshold.
// - A claim read returns the best source id and clears its pending bit.
// - After a claim the notification drops for at least one cycle.
// - A gateway ignores its source after reporting until a completion arrives.
// - A completion write naming a source releases that source's gateway.
// - Pending bits are readable and writable for software interrupts.
// - Vector mode select is bit 1 of control register 0x7d0, reset 0.
// - Vectored delivery needs both vector mode select and feature vectored enable.
// - Pending writes set bits on ones and leave bits on zeros.
`ifndef PIC_DEFS_SVH
`define PIC_DEFS_SVH
`define PIC_NSRC 46
`define PIC_ID_W 6
`define PIC_PRI_W 2
`define PIC_CSR_MISC 12'h7d0
`define PIC_VEC_BIT 1
`define PIC_PRI_RESET 2'h1
`define PIC_THR_RESET 2'h0
`endif

// ---- verilog/pic_gateways.sv ----
// Per-source interrupt gateways
`timescale 1ns/10ps
`default_nettype none
`include "pic_defs.svh"
module pic_gateways
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic srst,
	// Sources and completion
	input wire pic_pkg::pic_vec_t src_level,
	input wire logic compl_we,
	input wire pic_pkg::pic_id_t compl_id,
	// Requests to the core
	output logic [`PIC_NSRC:1] gw_req
);
	import pic_pkg::*;
	pic_gw_st_t s;
	pic_gw_st_t next_s;
	wire logic [`PIC_NSRC:1] next_busy;
	wire logic [`PIC_NSRC:1] next_req;

	////////////////////////////////////////////////////////////////////////////////
	// One gateway per source
	// Completion frees the gateway; the level is seen again next cycle
	genvar g;
	generate
		for (g = 1; g <= `PIC_NSRC; g++)
		begin : gen_gw
			assign next_req[g] = src_level[g] && !s.busy[g] && !(compl_we && compl_id == pic_id_t'(g));
			assign next_busy[g] = (compl_we && compl_id == pic_id_t'(g)) ? 1'b0
				: (s.busy[g] | next_req[g]);
		end
	endgenerate

	always_comb
	begin
		next_s.busy = next_busy;
		next_s.req = next_req;
	end

	always_ff @(posedge core_clk)
	begin
		if (srst)
			s <= '0;
		else
			s <= next_s;
	end

	assign gw_req = s.req;

	////////////////////////////////////////////////////////////////////////////////
	// Checks
	AST_GW_ONCE: assert property (@(posedge core_clk) disable iff (srst)
		(s.req & $past(s.busy)) == '0) else $error("gateway forwarded while busy");
	AST_GW_FWD: assert property (@(posedge core_clk) disable iff (srst)
		(|(src_level & ~s.busy) && !compl_we) |=> |s.req) else $error("level not forwarded");
	AST_GW_REL: assert property (@(posedge core_clk) disable iff (srst)
		compl_we && compl_id == pic_id_t'(5) && src_level[5] |=> ##1 s.req[5])
		else $error("completion did not release gateway");
endmodule // pic_gateways
`default_nettype wire

// ---- verilog/pic_pkg.sv ----
// Types of the platform interrupt controller
`include "pic_defs.svh"
package pic_pkg;
	typedef logic [`PIC_ID_W-1:0] pic_id_t;
	typedef logic [`PIC_PRI_W-1:0] pic_pri_t;
	typedef logic [`PIC_NSRC:1] pic_vec_t;
	typedef struct packed
	{
		pic_vec_t busy;
		pic_vec_t req;
	} pic_gw_st_t;
	typedef struct packed
	{
		pic_vec_t pending;
		pic_vec_t enable;
		logic [`PIC_NSRC:1][`PIC_PRI_W-1:0] pri;
		pic_pri_t thres;
		logic vec_sel;
		logic fen_vec;
		logic vec_active;
		logic eip;
		pic_id_t claim_id;
		logic claim_valid;
		logic [31:0] csr_rdata;
	} pic_core_st_t;
endpackage

// ---- verilog/pic_top.sv ----
// Platform interrupt controller core with gateways and control register
`timescale 1ns/10ps
`default_nettype none
`include "pic_defs.svh"
module pic_top
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic srst,
	// Interrupt sources
	input wire pic_pkg::pic_vec_t src_level,
	// Enable and priority settings
	input wire logic enable_we,
	input wire pic_pkg::pic_vec_t enable_wdata,
	input wire logic pri_we,
	input wire pic_pkg::pic_id_t pri_sel,
	input wire pic_pkg::pic_pri_t pri_wdata,
	input wire logic thres_we,
	input wire pic_pkg::pic_pri_t thres_wdata,
	input wire logic fen_we,
	input wire logic fen_wdata,
	// Pending write
	input wire logic pend_we,
	input wire pic_pkg::pic_vec_t pend_wdata,
	// Claim and completion
	input wire logic claim_rd,
	input wire logic compl_we,
	input wire pic_pkg::pic_id_t compl_id,
	// Control register access
	input wire logic csr_we,
	input wire logic [11:0] csr_addr,
	input wire logic [31:0] csr_wdata,
	// Outputs
	output logic eip,
	output pic_pkg::pic_id_t claim_id,
	output logic claim_valid,
	output pic_pkg::pic_vec_t source_pending_bits,
	output pic_pkg::pic_vec_t source_enable_bits,
	output pic_pkg::pic_pri_t target_priority_threshold,
	output logic feature_vectored_enable,
	output logic vector_mode_select,
	output logic vectored_active,
	output logic [31:0] csr_rdata
);
	import pic_pkg::*;
	pic_core_st_t s;
	pic_core_st_t next_s;
	pic_vec_t gw_req;
	pic_id_t best_id;
	pic_pri_t best_pri;
	logic any_qual;

	////////////////////////////////////////////////////////////////////////////////
	// Gateways
	pic_gateways u_gw
	(
		.core_clk(core_clk),
		.srst(srst),
		.src_level(src_level),
		.compl_we(compl_we),
		.compl_id(compl_id),
		.gw_req(gw_req)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Arbitration
	// Descending scan with >= makes the lowest id win a tie
	always_comb
	begin
		best_id = '0;
		best_pri = s.thres;
		for (int i = `PIC_NSRC; i >= 1; i--)
		begin
			if (s.pending[i] && s.enable[i] && s.pri[i] > s.thres
				&& (best_id == '0 || s.pri[i] >= best_pri))
			begin
				best_id = pic_id_t'(i);
				best_pri = s.pri[i];
			end
		end
		any_qual = (best_id != '0);
	end

	////////////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb
	begin
		next_s = s;
		// Settings; software must hold them stable while interrupts are open
		if (enable_we)
			next_s.enable = enable_wdata;
		if (pri_we && pri_sel != '0 && pri_sel <= pic_id_t'(`PIC_NSRC))
			next_s.pri[pri_sel] = (pri_wdata == '0) ? `PIC_PRI_RESET : pri_wdata;
		if (thres_we)
			next_s.thres = thres_wdata;
		if (fen_we)
			next_s.fen_vec = fen_wdata;
		if (csr_we && csr_addr == `PIC_CSR_MISC)
			next_s.vec_sel = csr_wdata[`PIC_VEC_BIT];
		next_s.csr_rdata = '0;
		if (csr_addr == `PIC_CSR_MISC)
			next_s.csr_rdata[`PIC_VEC_BIT] = s.vec_sel;
		next_s.vec_active = s.vec_sel && s.fen_vec;
		// Claim clears first so that a same-cycle set wins
		next_s.claim_valid = claim_rd;
		if (claim_rd)
		begin
			next_s.claim_id = best_id;
			if (any_qual)
				next_s.pending[best_id] = 1'b0;
		end
		next_s.pending = next_s.pending | gw_req;
		if (pend_we)
			next_s.pending = next_s.pending | pend_wdata;
		// A claim forces one low cycle so the core sees a fresh edge
		next_s.eip = any_qual && !claim_rd;
	end

	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			s <= '0;
			s.pri <= {`PIC_NSRC{`PIC_PRI_RESET}};
			s.thres <= `PIC_THR_RESET;
		end
		else
			s <= next_s;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs
	assign eip = s.eip;
	assign claim_id = s.claim_id;
	assign claim_valid = s.claim_valid;
	assign source_pending_bits = s.pending;
	assign source_enable_bits = s.enable;
	assign target_priority_threshold = s.thres;
	assign feature_vectored_enable = s.fen_vec;
	assign vector_mode_select = s.vec_sel;
	assign vectored_active = s.vec_active;
	assign csr_rdata = s.csr_rdata;

	////////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (srst);

	AST_EIP_DROP: assert property (claim_rd |=> !eip)
		else $error("eip stayed high after claim");
	AST_EIP_QUAL: assert property (eip |-> $past(any_qual) && !$past(claim_rd))
		else $error("eip without qualifying source");
	AST_EIP_RISE: assert property (any_qual && !claim_rd |=> eip)
		else $error("eip missing while source qualifies");
	AST_CLAIM_CLR: assert property (claim_rd && any_qual && !pend_we |=>
		claim_valid && claim_id == $past(best_id) && !s.pending[$past(best_id)])
		else $error("claim did not clear pending bit");
	AST_CLAIM_ZERO: assert property (claim_rd && !any_qual |=> claim_id == '0)
		else $error("empty claim returned nonzero id");
	AST_LATCH: assert property (|gw_req |=> (s.pending & $past(gw_req)) == $past(gw_req))
		else $error("gateway request not latched");
	AST_W1S: assert property (pend_we |=> (s.pending & $past(pend_wdata)) == $past(pend_wdata))
		else $error("pending write did not set");
	AST_W0_KEEP: assert property (pend_we && !claim_rd |=> (s.pending & $past(s.pending)) == $past(s.pending))
		else $error("pending write cleared a bit");
	AST_VEC: assert property (vectored_active |-> $past(s.vec_sel) && $past(s.fen_vec))
		else $error("vectored without both enables");
	AST_CSR: assert property (csr_we && csr_addr == `PIC_CSR_MISC |=> ##1
		csr_rdata[`PIC_VEC_BIT] == $past(csr_wdata[`PIC_VEC_BIT], 2) || $past(csr_addr) != `PIC_CSR_MISC
		|| $past(csr_we))
		else $error("control bit readback wrong");
	AST_PRI: assert property (pri_we && pri_sel == pic_id_t'(3) |=> s.pri[3] != '0)
		else $error("priority zero stored");

	COV_CLAIM: cover property (claim_rd && any_qual ##1 claim_id != '0);
	COV_EIP: cover property (!eip ##1 eip);
	COV_SWI: cover property (pend_we ##2 eip);
	COV_COMPL: cover property (compl_we ##1 compl_we);
endmodule // pic_top
`default_nettype wire
